/* File: include/exec_pkg.sv */
package exec_pkg;

  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_OPND = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_PC = 8'h10;
  localparam logic [7:0] ADDR_REG_SEL = 8'h14;
  localparam logic [7:0] ADDR_REG_DATA = 8'h18;

  // ==========================================================
  // command word fields
  localparam int CMD_W = 17;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_REG_LSB = 5;
  localparam int CMD_BIT_LSB = 10;
  localparam int CMD_PTR_LSB = 13;
  localparam int CMD_MODE_LSB = 15;
  localparam int OPND_W = 16;
  localparam int STATUS_BUSY = 0;
  localparam int STATUS_TAKEN = 1;

  // ==========================================================
  // status flag positions in cur_reg.flags
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ==========================================================
  // pointers, addressing and program counter
  localparam logic [4:0] PTR_BASE_IDX = 5'h1A;
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_POST_INC = 2'h1;
  localparam logic [1:0] MODE_PRE_DEC = 2'h2;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam int IO_ADDR_W = 5;
  localparam int DISP_W = 6;
  localparam int BR_OFFSET_W = 7;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_STEP_LONG = 16'h0002;

  typedef enum logic [4:0] {
    NOP_OP = 5'h00,
    BRANCH_OVERFLOW_CLEAR = 5'h01,
    BRANCH_IRQ_ENABLED = 5'h02,
    BRANCH_IRQ_DISABLED = 5'h03,
    IO_BIT_SET_OP = 5'h04,
    IO_BIT_CLEAR_OP = 5'h05,
    LOGICAL_RIGHT_SHIFT_OP = 5'h06,
    ROTATE_LEFT_CARRY_OP = 5'h07,
    ROTATE_RIGHT_CARRY_OP = 5'h08,
    ARITH_RIGHT_SHIFT_OP = 5'h09,
    BIT_TO_TRANSFER_FLAG_OP = 5'h0A,
    TRANSFER_FLAG_TO_BIT_OP = 5'h0B,
    FLAG_SET_OP = 5'h0C,
    FLAG_CLEAR_OP = 5'h0D,
    INDIRECT_LOAD_OP = 5'h0E,
    DISPLACED_LOAD_OP = 5'h0F,
    ABSOLUTE_LOAD_OP = 5'h10,
    INDIRECT_STORE_OP = 5'h11
  } op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_EXEC = 3'b010,
    S_MEM = 3'b100
  } state_t;

endpackage

/* File: core/shift_unit.sv */
`timescale 1ns/1ps

module shift_unit
  import exec_pkg::*;
(
  input wire op_t op_in,
  input wire logic [7:0] din_in,
  input wire logic [7:0] flags_in,
  output logic [7:0] dout_out,
  output logic [7:0] flags_out
);

  logic c_new;
  logic n_new;
  logic v_new;

  // ==========================================================
  // shift and rotate datapath
  always_comb begin
    dout_out = din_in;
    c_new = din_in[0];
    case (op_in)
      // RULE4: zero into bit 7
      LOGICAL_RIGHT_SHIFT_OP: dout_out = {1'b0, din_in[7:1]};
      // RULE5: carry in, end bit out
      ROTATE_RIGHT_CARRY_OP: dout_out = {flags_in[FLAG_C], din_in[7:1]};
      ROTATE_LEFT_CARRY_OP: begin
        dout_out = {din_in[6:0], flags_in[FLAG_C]};
        c_new = din_in[7];
      end
      // RULE6: bit 7 kept
      ARITH_RIGHT_SHIFT_OP: dout_out = {din_in[7], din_in[7:1]};
      default: dout_out = din_in;
    endcase
    n_new = dout_out[7];
    v_new = n_new ^ c_new;
    flags_out = flags_in;
    flags_out[FLAG_C] = c_new;
    flags_out[FLAG_Z] = (dout_out == 8'h00);
    flags_out[FLAG_N] = n_new;
    flags_out[FLAG_V] = v_new;
    // sign tracks n xor v so signed branches stay consistent
    flags_out[FLAG_S] = n_new ^ v_new;
    if (op_in == ROTATE_LEFT_CARRY_OP) begin
      flags_out[FLAG_H] = din_in[3];
    end
  end

endmodule

/* File: core/exec_core.sv */
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps

// How it works
// RULE1: overflow-clear branch jumps to pc+k+1 when v is 0; 1 or 2 cycles.
// RULE2: irq branches test global interrupt flag set or clear; 1 or 2 cycles.
// RULE3: io bit set or clear forces one io bit, flags kept, two cycles.
// RULE4: logical right shift, zero into bit 7, flags z c n v, one cycle.
// RULE5: rotates pass old carry in at one end, leaving bit to carry.
// RULE6: arithmetic right shift keeps bit 7, updates z c n v.
// RULE7: bit store copies selected register bit into transfer flag, one cycle.
// RULE8: bit load copies transfer flag into selected register bit, one cycle.
// RULE9: each status flag has own one-cycle set and clear.
// RULE10: sign flag set forces s to 1, clear forces it to 0.
// RULE11: post-increment load reads at pointer, then bumps pointer; two cycles.
// RULE12: pre-decrement load lowers pointer first, then reads new address.
// RULE13: displaced load reads y or z plus displacement, pointer untouched.
// RULE14: direct load reads absolute address into register, two cycles.
// RULE15: post-increment store writes source at x, then bumps x.
// RULE16: branch offset is signed two's complement, forward and back.
module exec_core
  import exec_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic [31:0] hrdata_out,
  output logic hresp_out,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_we_out,
  output logic mem_re_out,
  input wire logic [7:0] mem_rdata_in,
  output logic busy_out
);

  typedef struct packed {
    state_t state;
    logic [31:0][7:0] gpr;
    logic [7:0] flags;
    logic [15:0] pc;
    logic [CMD_W-1:0] cmd;
    logic [OPND_W-1:0] opnd;
    logic [4:0] reg_sel;
    logic taken;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic mem_re;
    logic busy;
  } core_state_t;

  core_state_t cur_reg;
  core_state_t cur_next;

  // ==========================================================
  // command decode
  op_t op;
  logic [4:0] rd;
  logic [2:0] bsel;
  logic [1:0] psel;
  logic [1:0] pmode;
  logic [4:0] pidx_lo;
  logic [4:0] pidx_hi;
  logic [15:0] ptr_val;
  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] br_target;
  logic [15:0] io_addr;
  logic [7:0] bit_mask;
  logic [7:0] sh_dout;
  logic [7:0] sh_flags;
  logic br_cond;
  logic addr_phase;

  assign op = op_t'(cur_reg.cmd[CMD_OP_LSB +: 5]);
  assign rd = cur_reg.cmd[CMD_REG_LSB +: 5];
  assign bsel = cur_reg.cmd[CMD_BIT_LSB +: 3];
  assign psel = cur_reg.cmd[CMD_PTR_LSB +: 2];
  assign pmode = cur_reg.cmd[CMD_MODE_LSB +: 2];
  assign pidx_lo = 5'(PTR_BASE_IDX + {2'b00, psel, 1'b0});
  assign pidx_hi = 5'(pidx_lo + 5'h01);
  assign ptr_val = {cur_reg.gpr[pidx_hi], cur_reg.gpr[pidx_lo]};
  assign ptr_inc = 16'(ptr_val + 16'h0001);
  assign ptr_dec = 16'(ptr_val - 16'h0001);
  // RULE16: signed offset
  assign br_target = 16'(cur_reg.pc + PC_STEP
    + {{(16 - BR_OFFSET_W){cur_reg.opnd[BR_OFFSET_W-1]}},
       cur_reg.opnd[BR_OFFSET_W-1:0]});
  assign io_addr = 16'(IO_BASE + {11'h000, cur_reg.opnd[IO_ADDR_W-1:0]});
  assign bit_mask = 8'(8'h01 << bsel);
  assign addr_phase = hsel_in && htrans_in[1] && hready_in;

  always_comb begin
    case (op)
      // RULE1: taken when v clear
      BRANCH_OVERFLOW_CLEAR: br_cond = ~cur_reg.flags[FLAG_V];
      // RULE2: taken on i set or clear
      BRANCH_IRQ_ENABLED: br_cond = cur_reg.flags[FLAG_I];
      BRANCH_IRQ_DISABLED: br_cond = ~cur_reg.flags[FLAG_I];
      default: br_cond = 1'b0;
    endcase
  end

  shift_unit u_shift (
    .op_in(op),
    .din_in(cur_reg.gpr[rd]),
    .flags_in(cur_reg.flags),
    .dout_out(sh_dout),
    .flags_out(sh_flags)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    cur_next = cur_reg;
    cur_next.mem_we = 1'b0;
    cur_next.mem_re = 1'b0;
    cur_next.hreadyout = 1'b1;

    // bus write data phase; state changes only while idle so a
    // running instruction never sees its operands move under it
    if (cur_reg.wr_pend) begin
      cur_next.wr_pend = 1'b0;
      if (cur_reg.state == S_IDLE) begin
        case (cur_reg.wr_addr)
          ADDR_CMD: begin
            cur_next.cmd = hwdata_in[CMD_W-1:0];
            cur_next.state = S_EXEC;
          end
          ADDR_OPND: cur_next.opnd = hwdata_in[OPND_W-1:0];
          ADDR_FLAGS: cur_next.flags = hwdata_in[7:0];
          ADDR_PC: cur_next.pc = hwdata_in[15:0];
          ADDR_REG_SEL: cur_next.reg_sel = hwdata_in[4:0];
          ADDR_REG_DATA: cur_next.gpr[cur_reg.reg_sel] = hwdata_in[7:0];
          default: cur_next.wr_pend = 1'b0;
        endcase
      end
    end

    // ========================================================
    // instruction execution
    case (cur_reg.state)
      S_EXEC: begin
        cur_next.state = S_IDLE;
        cur_next.pc = 16'(cur_reg.pc + PC_STEP);
        case (op)
          BRANCH_OVERFLOW_CLEAR, BRANCH_IRQ_ENABLED,
          BRANCH_IRQ_DISABLED: begin
            cur_next.taken = br_cond;
            // RULE2: second cycle only when taken
            if (br_cond) begin
              cur_next.pc = cur_reg.pc;
              cur_next.state = S_MEM;
            end
          end
          IO_BIT_SET_OP, IO_BIT_CLEAR_OP: begin
            // RULE3: read side of read-modify-write
            cur_next.mem_addr = io_addr;
            cur_next.mem_re = 1'b1;
            cur_next.pc = cur_reg.pc;
            cur_next.state = S_MEM;
          end
          LOGICAL_RIGHT_SHIFT_OP, ROTATE_LEFT_CARRY_OP,
          ROTATE_RIGHT_CARRY_OP, ARITH_RIGHT_SHIFT_OP: begin
            // RULE4: result and flags in one cycle
            cur_next.gpr[rd] = sh_dout;
            cur_next.flags = sh_flags;
          end
          BIT_TO_TRANSFER_FLAG_OP: begin
            // RULE7: only t changes
            cur_next.flags[FLAG_T] = cur_reg.gpr[rd][bsel];
          end
          TRANSFER_FLAG_TO_BIT_OP: begin
            // RULE8: flags untouched
            cur_next.gpr[rd][bsel] = cur_reg.flags[FLAG_T];
          end
          FLAG_SET_OP: begin
            // RULE9: one flag, bit field selects it
            // RULE10: selecting s gives the sign set
            cur_next.flags[bsel] = 1'b1;
          end
          FLAG_CLEAR_OP: begin
            // RULE9: one flag cleared
            // RULE10: selecting s gives the sign clear
            cur_next.flags[bsel] = 1'b0;
          end
          INDIRECT_LOAD_OP: begin
            cur_next.mem_re = 1'b1;
            cur_next.pc = cur_reg.pc;
            cur_next.state = S_MEM;
            if (pmode == MODE_PRE_DEC) begin
              // RULE12: pointer lowered before the read
              cur_next.mem_addr = ptr_dec;
              cur_next.gpr[pidx_lo] = ptr_dec[7:0];
              cur_next.gpr[pidx_hi] = ptr_dec[15:8];
            end else begin
              cur_next.mem_addr = ptr_val;
            end
          end
          DISPLACED_LOAD_OP: begin
            // RULE13: pointer plus displacement, pointer kept
            cur_next.mem_addr = 16'(ptr_val
              + {10'h000, cur_reg.opnd[DISP_W-1:0]});
            cur_next.mem_re = 1'b1;
            cur_next.pc = cur_reg.pc;
            cur_next.state = S_MEM;
          end
          ABSOLUTE_LOAD_OP: begin
            // RULE14: address from operand word
            cur_next.mem_addr = cur_reg.opnd;
            cur_next.mem_re = 1'b1;
            cur_next.pc = cur_reg.pc;
            cur_next.state = S_MEM;
          end
          INDIRECT_STORE_OP: begin
            // RULE15: write at pointer
            cur_next.mem_addr = ptr_val;
            cur_next.mem_wdata = cur_reg.gpr[rd];
            cur_next.mem_we = 1'b1;
            cur_next.pc = cur_reg.pc;
            cur_next.state = S_MEM;
          end
          default: cur_next.state = S_IDLE;
        endcase
      end
      S_MEM: begin
        cur_next.state = S_IDLE;
        cur_next.pc = 16'(cur_reg.pc + PC_STEP);
        case (op)
          BRANCH_OVERFLOW_CLEAR, BRANCH_IRQ_ENABLED,
          BRANCH_IRQ_DISABLED: begin
            // RULE1: pc plus offset plus one
            cur_next.pc = br_target;
          end
          IO_BIT_SET_OP: begin
            // RULE3: write back with one bit forced high;
            // the write strobe lands the cycle after, posted
            cur_next.mem_wdata = mem_rdata_in | bit_mask;
            cur_next.mem_we = 1'b1;
          end
          IO_BIT_CLEAR_OP: begin
            // RULE3: write back with one bit forced low
            cur_next.mem_wdata = mem_rdata_in & ~bit_mask;
            cur_next.mem_we = 1'b1;
          end
          INDIRECT_LOAD_OP: begin
            cur_next.gpr[rd] = mem_rdata_in;
            // RULE11: pointer bumped after the read
            if (pmode == MODE_POST_INC) begin
              cur_next.gpr[pidx_lo] = ptr_inc[7:0];
              cur_next.gpr[pidx_hi] = ptr_inc[15:8];
            end
          end
          DISPLACED_LOAD_OP: begin
            // RULE13: data captured, no flag change
            cur_next.gpr[rd] = mem_rdata_in;
          end
          ABSOLUTE_LOAD_OP: begin
            // RULE14: two-word instruction advances pc by two
            cur_next.gpr[rd] = mem_rdata_in;
            cur_next.pc = 16'(cur_reg.pc + PC_STEP_LONG);
          end
          INDIRECT_STORE_OP: begin
            // RULE15: pointer bumped after the write
            if (pmode == MODE_POST_INC) begin
              cur_next.gpr[pidx_lo] = ptr_inc[7:0];
              cur_next.gpr[pidx_hi] = ptr_inc[15:8];
            end
          end
          default: cur_next.state = S_IDLE;
        endcase
      end
      S_IDLE: cur_next.state = cur_next.state;
      default: cur_next.state = S_IDLE;
    endcase
    // registered copy so busy_out comes off a flop
    cur_next.busy = (cur_next.state != S_IDLE);

    // ========================================================
    // bus address phase; read data is latched here from the
    // updated copy so a read right after a write sees the write
    if (addr_phase) begin
      cur_next.wr_pend = hwrite_in;
      cur_next.wr_addr = haddr_in[7:0];
      cur_next.hrdata = 32'h0000_0000;
      if (!hwrite_in) begin
        case (haddr_in[7:0])
          ADDR_CMD: cur_next.hrdata = {15'h0000, cur_next.cmd};
          ADDR_OPND: cur_next.hrdata = {16'h0000, cur_next.opnd};
          ADDR_STATUS: begin
            cur_next.hrdata[STATUS_BUSY] = (cur_next.state != S_IDLE);
            cur_next.hrdata[STATUS_TAKEN] = cur_next.taken;
          end
          ADDR_FLAGS: cur_next.hrdata = {24'h000000, cur_next.flags};
          ADDR_PC: cur_next.hrdata = {16'h0000, cur_next.pc};
          ADDR_REG_SEL: cur_next.hrdata = {27'h0000000, cur_next.reg_sel};
          ADDR_REG_DATA:
            cur_next.hrdata =
              {24'h000000, cur_next.gpr[cur_next.reg_sel]};
          default: cur_next.hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // state register, synchronous reset
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      cur_reg <= '0;
      cur_reg.state <= S_IDLE;
      cur_reg.hreadyout <= 1'b1;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ==========================================================
  // outputs straight from the state register, hresp_out tied low
  assign hreadyout_out = cur_reg.hreadyout;
  assign hrdata_out = cur_reg.hrdata;
  // zero-wait slave, every response okay
  assign hresp_out = 1'b0;
  assign mem_addr_out = cur_reg.mem_addr;
  assign mem_wdata_out = cur_reg.mem_wdata;
  assign mem_we_out = cur_reg.mem_we;
  assign mem_re_out = cur_reg.mem_re;
  assign busy_out = cur_reg.busy;

endmodule

/* File: tb/exec_checker.sv */
`timescale 1ns/1ps

// ==========================================
// execution timing and data-space checks
module exec_checker
  import exec_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [15:0] mem_addr_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic mem_we_out,
  input wire logic mem_re_out,
  input wire logic [7:0] mem_rdata_in,
  input wire logic busy_out
);
  logic pend_reg;
  logic [7:0] pa_reg;
  logic [16:0] cmd_reg;
  logic [15:0] opnd_reg;
  logic [4:0] op;
  logic quick;
  logic io;
  logic is_load;
  logic [7:0] mask;

  // shadow of the accepted command; writes while busy are dropped
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pend_reg <= 1'b0;
      pa_reg <= 8'h00;
      cmd_reg <= 17'h00000;
      opnd_reg <= 16'h0000;
    end else begin
      pend_reg <= hsel_in & htrans_in[1] & hready_in & hwrite_in;
      pa_reg <= haddr_in[7:0];
      if (pend_reg && !busy_out && pa_reg == ADDR_CMD)
        cmd_reg <= hwdata_in[16:0];
      if (pend_reg && !busy_out && pa_reg == ADDR_OPND)
        opnd_reg <= hwdata_in[15:0];
    end
  end

  assign op = cmd_reg[4:0];
  assign quick = op == 5'h00 || (op > 5'h05 && op < 5'h0E) || op > 5'h11;
  assign io = op == 5'h04 || op == 5'h05;
  assign is_load = op > 5'h0D && op < 5'h11;
  assign mask = 8'h01 << cmd_reg[12:10];

  // ==========================================
  // properties
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence one_busy;
    busy_out ##1 !busy_out;
  endsequence
  sequence two_busy;
    busy_out [*2] ##1 !busy_out;
  endsequence
  sequence one_read;
    !mem_re_out ##1 mem_re_out ##1 !mem_re_out;
  endsequence

  a_quick_one_cycle: assert property (
    $rose(busy_out) && quick |-> one_busy)
    else $error("single cycle op busy length wrong");
  a_branch_timing: assert property (
    $rose(busy_out) && op inside {[5'h01:5'h03]} |-> ##[1:2] !busy_out)
    else $error("branch took more than two cycles");
  a_mem_two_cycles: assert property (
    $rose(busy_out) && (io || is_load || op == 5'h11) |-> two_busy)
    else $error("memory op busy length wrong");
  a_load_one_read: assert property (
    $rose(busy_out) && is_load |-> one_read)
    else $error("load read strobe misplaced");
  a_io_write_back: assert property (
    io && mem_re_out |=> mem_we_out && $stable(mem_addr_out))
    else $error("io bit write back missing");
  a_io_bit_value: assert property (
    io && mem_we_out |-> mem_wdata_out == (op == 5'h04 ?
      $past(mem_rdata_in) | mask : $past(mem_rdata_in) & ~mask))
    else $error("io bit write data wrong");
  a_io_address: assert property (
    io && mem_re_out |-> mem_addr_out == IO_BASE + 16'(opnd_reg[4:0]))
    else $error("io address wrong");
  a_abs_load_addr: assert property (
    op == 5'h10 && mem_re_out |-> mem_addr_out == opnd_reg)
    else $error("direct load address wrong");
  a_store_one_write: assert property (
    $rose(busy_out) && op == 5'h11 |->
      !mem_we_out ##1 (mem_we_out && !mem_re_out) ##1 !mem_we_out)
    else $error("store write strobe misplaced");
  a_quick_no_mem: assert property (
    busy_out && quick |-> !mem_re_out && !mem_we_out)
    else $error("register op touched memory");
endmodule

bind exec_core exec_checker i_exec_checker (.sys_clk_in, .rstn_in,
  .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in,
  .mem_addr_out, .mem_wdata_out, .mem_we_out, .mem_re_out,
  .mem_rdata_in, .busy_out);

/* File: tb/dmem_model.sv */
`timescale 1ns/1ps

// ==========================================
// data space model, asynchronous read
module dmem_model (
  input wire logic clk_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic we_in,
  input wire logic re_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [65536];
  logic [7:0] last_reg = 8'h00;

  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i * 37 + 5);
  // idle bus shows inverse of last data so stale reads get caught
  assign rdata_out = re_in ? mem[addr_in] : ~last_reg;
  always @(posedge clk_in) begin
    if (re_in) last_reg <= mem[addr_in];
    if (we_in) mem[addr_in] <= wdata_in;
  end
endmodule

/* File: tb/cpu_branch_bit_load_exec_bench.sv */
`timescale 1ns/1ps

// ==========================================
// bench top
module cpu_branch_bit_load_exec_bench;
  import exec_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hrdy, resp, we, re, busy;
  logic [15:0] ma;
  logic [7:0] mw, mr;
  int fail_count = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h0001319C;
  logic [7:0] g [32];
  logic [7:0] fl;
  logic [15:0] pc;

  exec_core i_exec_core (.sys_clk_in(clk), .rstn_in(rstn), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
    .hreadyout_out(hrdy), .hrdata_out(hrdata), .hresp_out(resp),
    .mem_addr_out(ma), .mem_wdata_out(mw), .mem_we_out(we),
    .mem_re_out(re), .mem_rdata_in(mr), .busy_out(busy));
  dmem_model i_dmem_model (.clk_in(clk), .addr_in(ma), .wdata_in(mw),
    .we_in(we), .re_in(re), .rdata_out(mr));

  initial begin
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // ==========================================
  // expected results
  function automatic logic [15:0] shf(input logic [4:0] op,
    input logic [7:0] d, input logic [7:0] f);
    logic [7:0] r;
    logic c;
    c = d[0];
    r = {f[FLAG_C], d[7:1]};
    if (op == 5'h06) r[7] = 1'b0;
    if (op == 5'h09) r[7] = d[7];
    if (op == 5'h07) begin
      r = {d[6:0], f[FLAG_C]};
      c = d[7];
      f[FLAG_H] = d[3];
    end
    f[FLAG_C] = c;
    f[FLAG_Z] = r == 8'h00;
    f[FLAG_N] = r[7];
    f[FLAG_V] = r[7] ^ c;
    // sign is n xor v, which reduces to the carry out
    f[FLAG_S] = c;
    return {f, r};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================
  // bus cycles
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v, e);
  endtask

  task automatic step(input logic [4:0] op, input logic [4:0] r,
    input logic [2:0] b, input logic [1:0] p, input logic [1:0] m,
    input logic [15:0] o);
    logic [15:0] pt, a;
    logic [7:0] ev;
    logic [31:0] s;
    logic tk, mchk;
    int n, cyc;
    pt = {g[27 + 2 * p], g[26 + 2 * p]};
    a = 16'h0000;
    ev = 8'h00;
    tk = 1'b0;
    mchk = 1'b0;
    cyc = op inside {[5'h04:5'h05], [5'h0E:5'h11]} ? 2 : 1;
    pc = pc + (op == 5'h10 ? PC_STEP_LONG : PC_STEP);
    case (op)
      5'h01: tk = !fl[FLAG_V];
      5'h02: tk = fl[FLAG_I];
      5'h03: tk = !fl[FLAG_I];
      5'h04, 5'h05: begin
        a = IO_BASE + 16'(o[4:0]);
        ev = i_dmem_model.mem[a];
        ev[b] = op == 5'h04;
        mchk = 1'b1;
      end
      5'h06, 5'h07, 5'h08, 5'h09: {fl, g[r]} = shf(op, g[r], fl);
      5'h0A: fl[FLAG_T] = g[r][b];
      5'h0B: g[r][b] = fl[FLAG_T];
      5'h0C: fl[b] = 1'b1;
      5'h0D: fl[b] = 1'b0;
      5'h0E, 5'h0F, 5'h10: begin
        if (op == 5'h0E && m == MODE_PRE_DEC) pt = pt - 16'h0001;
        a = op == 5'h10 ? o : (op == 5'h0F ? pt + 16'(o[5:0]) : pt);
        if (op == 5'h0E && m == MODE_POST_INC) pt = pt + 16'h0001;
        if (op == 5'h0E) {g[27 + 2 * p], g[26 + 2 * p]} = pt;
        g[r] = i_dmem_model.mem[a];
      end
      5'h11: begin
        a = pt;
        ev = g[r];
        mchk = 1'b1;
        {g[27], g[26]} = pt + 16'h0001;
      end
      default: ;
    endcase
    if (tk) begin
      pc = pc + {{9{o[6]}}, o[6:0]};
      cyc = 2;
    end
    wr(ADDR_OPND, {16'h0, o});
    wr(ADDR_CMD, {15'h0, m, p, b, r, op});
    n = 0;
    @(posedge clk);
    while (busy === 1'b1 && n < 8) begin
      n++;
      @(posedge clk);
    end
    chk(n, cyc);
    bus(1'b0, ADDR_STATUS, 32'h0, s);
    chk(s[0], 1'b0);
    if (op inside {[5'h01:5'h03]}) chk(s[1], tk);
    rdc(ADDR_PC, {16'h0, pc});
    rdc(ADDR_FLAGS, {24'h0, fl});
    for (int i = 0; i < 32; i++) begin
      wr(ADDR_REG_SEL, 32'(i));
      rdc(ADDR_REG_DATA, {24'h0, g[i]});
    end
    if (mchk) chk(i_dmem_model.mem[a], ev);
  endtask

  // ==========================================
  // scenarios
  initial begin
    logic [31:0] v;
    logic [4:0] op;
    logic [1:0] p;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (g[i]) g[i] = 8'h00;
    fl = 8'h00;
    pc = 16'h0000;
    rdc(ADDR_PC, 32'h0);
    rdc(ADDR_FLAGS, 32'h0);
    wr(8'h1C, 32'hFFFFFFFF);
    rdc(8'h1C, 32'h0);
    for (int i = 0; i < 32; i++) begin
      v = rnd();
      step(5'h10, 5'(i), 3'h0, 2'h0, 2'h0, v[15:0]);
    end
    // every flag set then cleared, sign included
    for (int i = 0; i < 16; i++)
      step(5'h0C + 5'(i % 2), 5'h0, 3'(i / 2), 2'h0, 2'h0, 16'h0);
    step(5'h0C, 5'h0, FLAG_I, 2'h0, 2'h0, 16'h0);
    step(5'h02, 5'h0, 3'h0, 2'h0, 2'h0, 16'h0040);
    step(5'h01, 5'h0, 3'h0, 2'h0, 2'h0, 16'h003F);
    step(5'h03, 5'h0, 3'h0, 2'h0, 2'h0, 16'h0040);
    // unknown code behaves as a plain one-cycle step
    step(5'h1F, 5'h0, 3'h0, 2'h0, 2'h0, 16'h0000);
    repeat (160) begin
      v = rnd();
      op = 5'(v % 18);
      p = op == 5'h0F ? 2'h1 + 2'(v[18]) : 2'(v[19:18] % 3);
      if (op == 5'h11) p = PTR_X;
      step(op, 5'(v[12:8] % 26), v[15:13], p,
        op == 5'h11 ? MODE_POST_INC : 2'(v[21:20] % 3), v[31:16]);
    end
    conclude();
  end

  initial begin
    #(25 * 60000);
    fail_count++;
    conclude();
  end
endmodule
